// ---- uxc_ctrl.sv ----
`timescale 1ns/100ps
// Overview of operation
// - bit 7 picks infrared pulse: 0 three-sixteenths, 1 quarter bit.
// - bit 5 inverts RTS in automatic direction mode.
// - bit 4 gives RTS to the transmitter; clear means no influence.
// - with bit 4 set, transmitter beats modem bit and flow control.
// - RTS low once a character is written, high after last bit.
// - bit 2 stops new characters; current one finishes; FIFO still fills.
// - bit 1 stops receiving at once and flushes the shifter.
// - bit 0 enables 9-bit multidrop; parity one marks an address.
// - multidrop, receiver off: drop data, store address with error flag.
// - receiver left on flags parity error on next address.
// - auto detect drops data while receiver off, and non-matching addresses.
// - matching address enables receiver, stored with parity, interrupt.
// - later non-matching address disables receiver and is dropped.

module uxc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         core_clk,  // clock
  input  wire logic         rst,       // sync reset
  input  wire logic         ce,        // clock enable
  input  wire logic         in_valid,  // write request
  input  wire logic [W-1:0] in_data,   // write data
  output logic              in_ready,  // room for a word
  output logic              out_valid, // word available
  output logic [W-1:0]      out_data,  // head word
  input  wire logic         out_ready  // drain side takes head
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    rdy;
  } uxc_fifo_st_t;

  uxc_fifo_st_t st_r;
  uxc_fifo_st_t st_nxt;
  logic         push;
  logic         pop;

  assign out_valid = (st_r.cnt != '0);
  assign out_data  = st_r.mem[st_r.rp];
  assign in_ready  = st_r.rdy;
  assign push      = in_valid & st_r.rdy;
  assign pop       = out_valid & out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp           = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // registered so the writer sees ready without a comparator in front
    st_nxt.rdy = (st_nxt.cnt != FULL_CNT);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r     <= '0;
      st_r.rdy <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule

module uxc_ctrl
  import uxc_pkg::*;
(
  input  wire logic                  core_clk,     // 125 MHz clock
  input  wire logic                  rst,          // sync reset, high
  input  wire logic                  ce,           // clock enable
  input  wire logic                  sw_reset,     // software reset pulse
  input  wire logic                  extra_features_control_wr_en,   // control register write
  input  wire logic [7:0]            extra_features_control_wdata,   // write data
  output logic [7:0]                 extra_features_control_rdata,   // read data
  input  wire logic                  mcr_rts,      // modem_control_register RTS level
  input  wire logic                  hw_flow_en,   // hardware flow control on
  input  wire logic                  hw_flow_rts,  // RTS level from flow control
  input  wire logic                  special_char_en, // enhanced_features_register bit 5
  input  wire logic [7:0]            second_pause_character, // station address
  input  wire logic                  ls_irq_en,    // interrupt_enable_register bit 2
  input  wire logic                  tx_wr_valid,  // host writes a character
  input  wire logic [UXC_DATA_W-1:0] tx_wr_data,   // character
  output logic                       tx_wr_ready,  // transmit FIFO has room
  output logic                       tx_sh_valid,  // character for shifter
  output logic [UXC_DATA_W-1:0]      tx_sh_data,   // character data
  input  wire logic                  tx_sh_ready,  // shifter takes character
  input  wire logic                  tx_sh_busy,   // shifter sending bits
  input  wire logic                  rx_char_valid, // shifter delivers a char
  input  wire logic [UXC_DATA_W-1:0] rx_char_data, // received data
  input  wire logic                  rx_char_parity, // received ninth bit
  input  wire logic                  rx_char_perr, // parity check failed
  output logic                       rx_enable,    // shifter may receive
  output logic                       rx_flush,     // push partial char, pulse
  output logic                       rx_push_valid, // write to receive FIFO
  output logic [UXC_DATA_W-1:0]      rx_push_data, // data to receive FIFO
  output logic                       rx_push_perr, // parity error position
  output logic                       ls_irq,       // line status event, pulse
  output logic                       rts_n,        // RTS pin level
  output logic                       irda_quarter  // quarter-bit infrared pulse
);
  import uxc_pkg::*;

  typedef struct packed {
    logic [7:0]            extra_features_control;
    logic                  rts;
    logic                  hold_v;
    logic [UXC_DATA_W-1:0] hold_d;
    logic                  push_v;
    logic [UXC_DATA_W-1:0] push_d;
    logic                  push_perr;
    logic                  lsi;
    logic                  flush;
    logic                  rx_en;
  } uxc_top_st_t;

  uxc_top_st_t           st_r;
  uxc_top_st_t           st_nxt;
  logic                  fifo_valid;
  logic [UXC_DATA_W-1:0] fifo_data;
  logic                  fifo_pop_rdy;
  logic                  fifo_in_rdy;
  logic                  pending;
  logic                  is_addr;
  logic                  match;
  logic                  auto_det;
  logic                  mdrop;

  uxc_fifo #(.W(UXC_DATA_W), .DEPTH(UXC_TXF_DEPTH)) u_txf (
    .core_clk  (core_clk),
    .rst       (rst | sw_reset),
    .ce        (ce),
    .in_valid  (tx_wr_valid),
    .in_data   (tx_wr_data),
    .in_ready  (fifo_in_rdy),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop_rdy)
  );

  // hold stage keeps tx_sh_* straight from flops
  assign fifo_pop_rdy = ~st_r.extra_features_control[UXC_B_TX_INH] & (~st_r.hold_v | tx_sh_ready);
  assign pending  = (tx_wr_valid & fifo_in_rdy) | fifo_valid | st_r.hold_v | tx_sh_busy;
  assign mdrop    = st_r.extra_features_control[UXC_B_MDROP];
  assign is_addr  = mdrop & (rx_char_parity == UXC_PAR_ADDR);
  assign auto_det = mdrop & special_char_en;
  assign match    = (rx_char_data == second_pause_character);

  always_comb begin
    st_nxt        = st_r;
    st_nxt.push_v = 1'b0;
    st_nxt.lsi    = 1'b0;
    st_nxt.flush  = 1'b0;
    if (extra_features_control_wr_en) begin
      st_nxt.extra_features_control = extra_features_control_wdata & UXC_EXTRA_FEATURES_CONTROL_WMSK;
    end
    // transmit hold stage
    if (fifo_valid & fifo_pop_rdy) begin
      st_nxt.hold_v = 1'b1;
      st_nxt.hold_d = fifo_data;
    end else if (tx_sh_ready) begin
      st_nxt.hold_v = 1'b0;
    end
    // receive classification; address logic wins over a same-cycle host write
    if (rx_char_valid) begin
      st_nxt.push_d = rx_char_data;
      if (auto_det) begin
        if (is_addr & match) begin
          st_nxt.extra_features_control[UXC_B_RX_INH] = 1'b0;
          st_nxt.push_v    = 1'b1;
          st_nxt.push_perr = rx_char_parity;
          st_nxt.lsi       = ls_irq_en;
        end else if (is_addr) begin
          st_nxt.extra_features_control[UXC_B_RX_INH] = 1'b1;
        end else begin
          st_nxt.push_v    = ~st_r.extra_features_control[UXC_B_RX_INH];
          st_nxt.push_perr = 1'b0;
        end
      end else if (mdrop) begin
        // forced parity zero makes every address a parity error
        st_nxt.push_v    = is_addr | ~st_r.extra_features_control[UXC_B_RX_INH];
        st_nxt.push_perr = is_addr;
        st_nxt.lsi       = is_addr & ls_irq_en;
      end else begin
        st_nxt.push_v    = ~st_r.extra_features_control[UXC_B_RX_INH];
        st_nxt.push_perr = rx_char_perr;
        st_nxt.lsi       = rx_char_perr & ~st_r.extra_features_control[UXC_B_RX_INH] & ls_irq_en;
      end
    end
    // multidrop keeps the shifter running to watch for addresses
    st_nxt.rx_en = ~st_nxt.extra_features_control[UXC_B_RX_INH] | st_nxt.extra_features_control[UXC_B_MDROP];
    st_nxt.flush = st_nxt.extra_features_control[UXC_B_RX_INH] & ~st_r.extra_features_control[UXC_B_RX_INH];
    // flow control assumed off by host while transmitter owns RTS
    if (st_r.extra_features_control[UXC_B_TX_RTS]) begin
      st_nxt.rts = st_r.extra_features_control[UXC_B_RTS_INV] ? pending : ~pending;
    end else begin
      st_nxt.rts = hw_flow_en ? hw_flow_rts : mcr_rts;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst | sw_reset) begin
      st_r        <= '0;
      st_r.extra_features_control   <= UXC_EXTRA_FEATURES_CONTROL_RST;
      st_r.rts    <= 1'b1;
      st_r.rx_en  <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign extra_features_control_rdata    = st_r.extra_features_control;
  assign tx_wr_ready   = fifo_in_rdy;
  assign tx_sh_valid   = st_r.hold_v;
  assign tx_sh_data    = st_r.hold_d;
  assign rx_enable     = st_r.rx_en;
  assign rx_flush      = st_r.flush;
  assign rx_push_valid = st_r.push_v;
  assign rx_push_data  = st_r.push_d;
  assign rx_push_perr  = st_r.push_perr;
  assign ls_irq        = st_r.lsi;
  assign rts_n         = st_r.rts;
  assign irda_quarter  = st_r.extra_features_control[UXC_B_IRDA];

  rsv_bits_a: assert property (@(posedge core_clk) disable iff (rst)
    extra_features_control_rdata[6] == 1'b0 && extra_features_control_rdata[3] == 1'b0)
    else $error("reserved control bits not zero");

  irda_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !sw_reset && extra_features_control_wr_en |=> irda_quarter == $past(extra_features_control_wdata[UXC_B_IRDA]))
    else $error("infrared pulse select does not follow bit 7");

  rts_auto_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !sw_reset && st_r.extra_features_control[UXC_B_TX_RTS] && !st_r.extra_features_control[UXC_B_RTS_INV]
    && tx_wr_valid && tx_wr_ready |=> !rts_n)
    else $error("RTS not low after a character was written");

  rts_inv_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !sw_reset && st_r.extra_features_control[UXC_B_TX_RTS] && st_r.extra_features_control[UXC_B_RTS_INV]
    && !pending |=> !rts_n)
    else $error("inverted RTS not low after last bit");

  rts_manual_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !sw_reset && !st_r.extra_features_control[UXC_B_TX_RTS] && !hw_flow_en |=> rts_n == $past(mcr_rts))
    else $error("RTS not from modem bit when transmitter does not own it");

  tx_inhibit_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !sw_reset && st_r.extra_features_control[UXC_B_TX_INH] && !tx_sh_valid |=> !tx_sh_valid)
    else $error("new character started while transmitter inhibited");

  rx_drop_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !sw_reset && rx_char_valid && mdrop && !special_char_en
    && st_r.extra_features_control[UXC_B_RX_INH] && !rx_char_parity |=> !rx_push_valid)
    else $error("data kept while multidrop receiver disabled");

  rx_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !sw_reset && rx_char_valid && mdrop && !special_char_en && rx_char_parity
    |=> rx_push_valid && rx_push_perr && ls_irq == $past(ls_irq_en))
    else $error("address not stored with parity error");

  auto_en_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !sw_reset && rx_char_valid && auto_det && rx_char_parity && match
    |=> rx_push_valid && rx_push_perr && !extra_features_control_rdata[UXC_B_RX_INH])
    else $error("matching address did not enable receiver");

  auto_dis_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !sw_reset && rx_char_valid && auto_det && rx_char_parity && !match
    |=> !rx_push_valid && extra_features_control_rdata[UXC_B_RX_INH])
    else $error("foreign address did not disable receiver");
endmodule

// ---- uxc_ctrl_tb.sv ----
`timescale 1ns/100ps
module uxc_ctrl_tb;
  import uxc_pkg::*;
  logic       core_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, modem_control_register = 1'b0, hfe = 1'b0;
  logic       hfr = 1'b0, spc = 1'b0, tx_v = 1'b0, iv;
  logic [7:0] wdata = 8'h00, txd = 8'h00, adr = 8'h5A, rd, pd;
  logic       tx_rdy, sh_v, sh_rdy, sh_busy, rv, rpar, rperr, rx_en, flush, pv, pe, irq;
  logic       rts_n, irda;
  logic [7:0] rdata, rxd;
  logic [9:0] expq[$];
  logic [7:0] txq[$];
  logic [7:0] shd, tch;
  logic       ce_i = 1'b1, sr = 1'b0, tkn;
  int         n_fail = 0, check_count = 0;
  always #4 core_clk = ~core_clk;
  uxc_ctrl i_uxc_ctrl (.core_clk(core_clk), .rst(rst), .ce(ce_i), .sw_reset(sr),
    .extra_features_control_wr_en(wr_en), .extra_features_control_wdata(wdata), .extra_features_control_rdata(rdata), .mcr_rts(modem_control_register),
    .hw_flow_en(hfe), .hw_flow_rts(hfr), .special_char_en(spc),
    .second_pause_character(adr), .ls_irq_en(1'b1), .tx_wr_valid(tx_v), .tx_wr_data(txd),
    .tx_wr_ready(tx_rdy), .tx_sh_valid(sh_v), .tx_sh_data(shd), .tx_sh_ready(sh_rdy),
    .tx_sh_busy(sh_busy), .rx_char_valid(rv), .rx_char_data(rxd), .rx_char_parity(rpar),
    .rx_char_perr(rperr), .rx_enable(rx_en), .rx_flush(flush), .rx_push_valid(pv),
    .rx_push_data(pd), .rx_push_perr(pe), .ls_irq(irq), .rts_n(rts_n), .irda_quarter(irda));
  uxc_partner i_uxc_partner (.core_clk(core_clk), .sh_valid(sh_v), .sh_data(shd),
    .sh_ready(sh_rdy), .sh_busy(sh_busy), .sh_taken(tkn), .sh_char(tch), .rx_valid(rv),
    .rx_data(rxd), .rx_parity(rpar), .rx_perr(rperr));
  task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] v);
    @(negedge core_clk);
    wr_en = 1'b1;
    wdata = v;
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask
  task automatic tx(logic [7:0] d);
    @(negedge core_clk);
    tx_v = 1'b1;
    txd = d;
    while (tx_rdy !== 1'b1) @(negedge core_clk);
    txq.push_back(d);
    @(negedge core_clk);
    tx_v = 1'b0;
  endtask
  // 10'h200 marks a character that must be dropped
  task automatic rx(logic [7:0] d, logic p, logic e, logic [9:0] ex);
    if (ex !== 10'h200) expq.push_back(ex);
    i_uxc_partner.send(d, p, e);
    repeat (2) @(negedge core_clk);
  endtask
  always @(negedge core_clk) if (pv === 1'b1 || irq === 1'b1) begin
    if (expq.size() == 0) begin
      n_fail++;
      $display("Error push expected none seen %h", {irq, pe, pd});
    end else chk("push", expq.pop_front(), {irq, pe, pd});
  end
  always @(negedge core_clk) if (tkn === 1'b1) begin
    if (txq.size() == 0) begin
      n_fail++;
      $display("Error tx_char expected none seen %h", tch);
    end else chk("tx_char", {2'b00, txq.pop_front()}, {2'b00, tch});
  end
  initial begin
    #(8 * 20000);
    n_fail++;
    give_verdict();
  end
  initial begin
    rd = 8'($urandom(69));
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    chk("extra_features_control", 10'h000, {2'b00, rdata});
    chk("rts", 10'h001, {9'h0, rts_n});
    wr(8'hFF);
    chk("extra_features_control", 10'h0B7, {2'b00, rdata});
    chk("irda", 10'h001, {9'h0, irda});
    chk("flush", 10'h001, {9'h0, flush});
    wr(8'h02);
    chk("rx_en", 10'h000, {9'h0, rx_en});
    wr(8'h00);
    chk("irda", 10'h000, {9'h0, irda});
    chk("rx_en", 10'h001, {9'h0, rx_en});
    ce_i = 1'b0;
    wr(8'h81);
    chk("frozen", 10'h000, {2'b00, rdata});
    ce_i = 1'b1;
    wr(8'h81);
    chk("extra_features_control", 10'h081, {2'b00, rdata});
    sr = 1'b1;
    @(negedge core_clk);
    sr = 1'b0;
    chk("sw_reset", 10'h100, {1'b0, rts_n, rdata});
    $display("test register done");
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      {hfe, hfr, modem_control_register} = 3'(i);
      @(negedge core_clk);
      chk("rts_src", {9'h0, hfe ? hfr : modem_control_register}, {9'h0, rts_n});
    end
    {hfe, hfr, modem_control_register} = 3'b000;
    for (int i = 0; i < 2; i++) begin
      iv = i[0];
      wr({2'b00, iv, 5'h10});
      @(negedge core_clk);
      chk("rts_idle", {9'h0, !iv}, {9'h0, rts_n});
      tx(8'($urandom));
      chk("rts_send", {9'h0, iv}, {9'h0, rts_n});
      for (int k = 0; k < 60 && rts_n !== !iv; k++) @(negedge core_clk);
      chk("rts_done", {9'h0, !iv}, {9'h0, rts_n});
    end
    $display("test rts done");
    wr(8'h14);
    repeat (16) tx(8'($urandom));
    chk("full", 10'h000, {9'h0, tx_rdy});
    chk("held", 10'h000, {9'h0, sh_v});
    wr(8'h10);
    for (int k = 0; k < 400 && rts_n !== 1'b1; k++) @(negedge core_clk);
    chk("drained", 10'h001, {9'h0, tx_rdy & rts_n});
    $display("test transmit done");
    wr(8'h00);
    rd = 8'($urandom);
    rx(rd, 1'b0, 1'b1, {2'b11, rd});
    rx(rd, 1'b0, 1'b0, {2'b00, rd});
    wr(8'h03);
    rx(rd, 1'b0, 1'b0, 10'h200);
    rx(rd, 1'b1, 1'b1, {2'b11, rd});
    wr(8'h01);
    rx(rd, 1'b0, 1'b0, {2'b00, rd});
    rx(~rd, 1'b1, 1'b1, {2'b11, ~rd});
    spc = 1'b1;
    wr(8'h03);
    rx(rd, 1'b0, 1'b0, 10'h200);
    rx(~adr, 1'b1, 1'b1, 10'h200);
    rx(adr, 1'b1, 1'b1, {2'b11, adr});
    chk("auto_on", 10'h001, {2'b00, rdata});
    rx(rd, 1'b0, 1'b0, {2'b00, rd});
    rx(adr, 1'b1, 1'b1, {2'b11, adr});
    rx(~adr, 1'b1, 1'b1, 10'h200);
    chk("auto_off", 10'h003, {2'b00, rdata});
    rx(rd, 1'b0, 1'b0, 10'h200);
    chk("leftover", 10'h000, 10'(expq.size() + txq.size()));
    $display("test receive done");
    give_verdict();
  end
endmodule

// ---- uxc_partner.sv ----
`timescale 1ns/100ps
module uxc_partner
  import uxc_pkg::*;
#(
  parameter int BUSY = 6
) (
  input  wire logic                  core_clk,  // clock
  input  wire logic                  sh_valid,  // character offered
  input  wire logic [UXC_DATA_W-1:0] sh_data,   // character data
  output logic                       sh_ready,  // shifter takes it
  output logic                       sh_busy,   // bits still leaving
  output logic                       sh_taken,  // character taken, pulse
  output logic [UXC_DATA_W-1:0]      sh_char,   // last character taken
  output logic                       rx_valid,  // character arrives
  output logic [UXC_DATA_W-1:0]      rx_data,   // received data
  output logic                       rx_parity, // ninth bit
  output logic                       rx_perr    // parity check failed
);
  int cnt = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_parity = 1'b0;
    rx_perr = 1'b0;
  end
  always @(posedge core_clk) begin
    sh_taken <= sh_valid && sh_ready;
    if (sh_valid && sh_ready) begin
      cnt     <= BUSY;
      sh_char <= sh_data;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // sometimes slow to accept, so the hold register really waits
  always @(negedge core_clk) begin
    sh_ready <= ($urandom % 3) != 0;
    sh_busy <= cnt != 0;
  end
  task automatic send(logic [7:0] d, logic p, logic e);
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx_data = d;
    rx_parity = p;
    rx_perr = e;
    @(negedge core_clk);
    rx_valid = 1'b0;
    // stale lines must not look like the last character
    rx_data = ~d;
    rx_parity = ~p;
  endtask
endmodule

// ---- uxc_pkg.sv ----
package uxc_pkg;
  localparam int          UXC_DATA_W    = 8;
  localparam int          UXC_TXF_DEPTH = 16;
  // extra_features_control bit positions
  localparam int          UXC_B_IRDA    = 7;
  localparam int          UXC_B_RTS_INV = 5;
  localparam int          UXC_B_TX_RTS  = 4;
  localparam int          UXC_B_TX_INH  = 2;
  localparam int          UXC_B_RX_INH  = 1;
  localparam int          UXC_B_MDROP   = 0;
  localparam logic [7:0]  UXC_EXTRA_FEATURES_CONTROL_RST  = 8'h00;
  // bits 6 and 3 are reserved
  localparam logic [7:0]  UXC_EXTRA_FEATURES_CONTROL_WMSK = 8'hB7;
  localparam logic        UXC_PAR_ADDR  = 1'b1;
endpackage
